/* File: rtl/ccs_pkg.sv */
package ccs_pkg;
// Functional notes
// - Cascade holds at most three units.
// - Whole cascade shares one beam coding.
// - Factory-fresh unit detects cascade membership itself.
// - Count units at power-up, store during configuration.
// - Fewer units than stored forces locking state.
// - More units than stored updates stored count.
// - Unconfigured unit adopts interlock and contactor settings.
// - Adopt a setting if any unit enables it.
// - Change or factory state: configuration mode, green flashing.
// - Correct cascade shown by flashing diagnostic LED 2.
// - Button held 1-3 s enables interlock, LED 4.
// - Receiver forwards output and field state to sender.
// - All LEDs light briefly after power-up.
// - Alignment quality on LEDs 1-4 after seconds.
// - LEDs 5-6 top beam, 7-8 bottom beam sync.
// - Normal operation shows configuration, main LEDs lit.
// - Contactor check off by default, factory reset clears.
// - Contactor check configured flashes diagnostic LED 1.

  localparam int unsigned CLK_NS   = 10;
  localparam int unsigned MS_NS    = 1_000_000;
  localparam int unsigned TICK_CYC = MS_NS / CLK_NS;
  localparam int unsigned DIV_W    = 17;
  localparam int unsigned MAX_UNITS = 3;

  localparam int unsigned LAMP_MS    = 500;
  localparam int unsigned ALIGN_MS   = 2000;
  localparam int unsigned BTN_MIN_MS = 1000;
  localparam int unsigned BTN_MAX_MS = 3000;
  localparam int unsigned FLASH_MS   = 250;
  localparam logic [11:0] LAMP_T    = 12'(LAMP_MS * MS_NS / MS_NS);
  localparam logic [11:0] ALIGN_T   = 12'(ALIGN_MS * MS_NS / MS_NS);
  localparam logic [11:0] BTN_MIN_T = 12'(BTN_MIN_MS * MS_NS / MS_NS);
  localparam logic [11:0] BTN_MAX_T = 12'(BTN_MAX_MS * MS_NS / MS_NS);
  localparam logic [7:0]  FLASH_T   = 8'(FLASH_MS * MS_NS / MS_NS);

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BEAM   = 8'h08;
  localparam int unsigned CTRL_FACTORY_BIT = 0;

  typedef enum logic [2:0] {
    S_INIT   = 3'b000,
    S_DETECT = 3'b001,
    S_CONFIG = 3'b010,
    S_RUN    = 3'b011,
    S_LOCK   = 3'b100
  } ccs_mode_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] count;
    logic       restart;
    logic       contactor;
  } ccs_nvm_t;

  typedef struct packed {
    logic       field_green;
    logic       field_red;
    logic       sender_state;
    logic       safety_switching_output;
    logic [7:0] diag;
  } ccs_led_t;

  typedef struct packed {
    logic safety_switching_output;
    logic field_free;
  } ccs_fwd_t;

  typedef struct packed {
    ccs_mode_t   mode;
    logic [16:0] div;
    logic [11:0] ms;
    logic [7:0]  blink_ms;
    logic        blink;
    ccs_nvm_t    cfg;
    logic [2:0]  found;
    logic [11:0] btn_ms;
    logic        btn_r;
    logic        ri_conf;
    logic [3:0]  beam;
    logic        nvm_wr;
    ccs_led_t    leds;
    ccs_fwd_t    fwd;
    logic [31:0] rdata;
  } ccs_state_t;

  localparam ccs_state_t ST_RST = '0;
endpackage

/* File: rtl/ccs_top.sv */
`timescale 1ns/100ps
module ccs_top #(
  parameter int unsigned TICK_CYC = ccs_pkg::TICK_CYC
) (
  // Clock and reset.
  input  wire  logic              clk,
  input  wire  logic              sys_rst,
  // Register port.
  input  wire  logic [7:0]        reg_addr,
  input  wire  logic [31:0]       reg_wdata,
  input  wire  logic              reg_wr,
  input  wire  logic              reg_rd,
  output logic [31:0]             reg_rdata,
  // Cascade chain.
  input  wire  logic              is_host,
  input  wire  logic [3:0]        beam_dip,
  input  wire  logic [3:0]        chain_beam,
  input  wire  logic              chain_valid,
  input  wire  logic [2:0]        chain_count,
  input  wire  logic              chain_restart_any,
  input  wire  logic              chain_contactor_any,
  output logic [3:0]              beam_code,
  output logic                    locked,
  // Non-volatile configuration store.
  input  wire  ccs_pkg::ccs_nvm_t nvm_rd,
  output logic                    nvm_wr,
  output ccs_pkg::ccs_nvm_t       nvm_wdata,
  // Receiver status and operator inputs.
  input  wire  logic              contactor_feedback_check,
  input  wire  logic              reset_button,
  input  wire  logic [2:0]        align_level,
  input  wire  logic              top_sync,
  input  wire  logic              bottom_sync,
  input  wire  logic              safety_switching_output,
  input  wire  logic              field_free,
  input  wire  logic              sender_linked,
  // Indicators.
  output ccs_pkg::ccs_led_t       leds,
  output ccs_pkg::ccs_fwd_t       fwd
);
  import ccs_pkg::*;

  ccs_state_t s;
  ccs_state_t n;
  logic       tick;
  logic       factory;
  logic       rel;

  function automatic logic [3:0] therm(input logic [2:0] lvl);
    therm = 4'h0;
    for (int i = 0; i < 4; i++) begin
      therm[i] = 3'(i) < lvl;
    end
  endfunction

  always_comb begin
    n = s;
    n.nvm_wr = 1'b0;
    n.rdata = '0;
    tick = s.div == DIV_W'(TICK_CYC - 1);
    n.div = tick ? '0 : s.div + 1'b1;
    if (tick) begin
      if (s.ms != '1) begin
        n.ms = s.ms + 1'b1;
      end
      if (s.blink_ms == FLASH_T - 1'b1) begin
        n.blink_ms = '0;
        n.blink = ~s.blink;
      end else begin
        n.blink_ms = s.blink_ms + 1'b1;
      end
    end
    n.btn_r = reset_button;
    rel = s.btn_r && !reset_button;
    factory = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_FACTORY_BIT];
    unique case (s.mode)
      S_INIT: begin
        if (tick && s.ms >= LAMP_T) begin
          n.mode = S_DETECT;
          n.ms = '0;
          n.cfg = nvm_rd;
        end
      end
      S_DETECT: begin
        if (chain_valid) begin
          n.found = chain_count;
          n.beam = is_host ? beam_dip : chain_beam;
          n.ms = '0;
          if (chain_count == 3'h0 || chain_count > 3'(MAX_UNITS)) begin
            n.mode = S_LOCK;
          end else if (!s.cfg.valid) begin
            n.mode = S_CONFIG;
            n.cfg.valid = 1'b1;
            n.cfg.count = chain_count[1:0];
            n.cfg.restart = chain_restart_any;
            n.cfg.contactor = chain_contactor_any | contactor_feedback_check;
            n.nvm_wr = 1'b1;
          end else if (chain_count < {1'b0, s.cfg.count}) begin
            n.mode = S_LOCK;
          end else if (chain_count > {1'b0, s.cfg.count}) begin
            n.mode = S_CONFIG;
            n.cfg.count = chain_count[1:0];
            n.nvm_wr = 1'b1;
          end else begin
            n.mode = S_RUN;
          end
        end
      end
      S_CONFIG: begin
        if (!reset_button) begin
          n.btn_ms = '0;
        end else if (tick && s.btn_ms <= BTN_MAX_T) begin
          n.btn_ms = s.btn_ms + 1'b1;
        end
        if (rel && s.btn_ms >= BTN_MIN_T && s.btn_ms <= BTN_MAX_T) begin
          n.cfg.restart = 1'b1;
          n.ri_conf = 1'b1;
          n.nvm_wr = 1'b1;
        end
      end
      S_RUN: begin
      end
      S_LOCK: begin
      end
    endcase
    if (factory) begin
      n.cfg = '0;
      n.nvm_wr = 1'b1;
    end
    n.leds = '0;
    unique case (s.mode)
      S_INIT: begin
        n.leds = '1;
      end
      S_DETECT: begin
      end
      S_CONFIG: begin
        n.leds.field_green = s.blink;
        n.leds.diag[0] = s.cfg.contactor && s.blink;
        n.leds.diag[1] = s.cfg.count > 2'h1 && s.blink;
        n.leds.diag[3] = s.ri_conf && s.blink;
      end
      S_RUN: begin
        n.leds.field_green = safety_switching_output;
        n.leds.field_red = !safety_switching_output;
        n.leds.sender_state = 1'b1;
        n.leds.safety_switching_output = 1'b1;
        if (s.ms >= ALIGN_T && !safety_switching_output) begin
          n.leds.diag[3:0] = therm(align_level);
          n.leds.diag[5:4] = {2{top_sync}};
          n.leds.diag[7:6] = {2{bottom_sync}};
        end else begin
          n.leds.diag[0] = s.cfg.contactor;
          n.leds.diag[1] = s.cfg.count > 2'h1;
          n.leds.diag[3] = s.cfg.restart;
        end
      end
      S_LOCK: begin
        n.leds.field_red = s.blink;
      end
    endcase
    n.fwd.safety_switching_output = sender_linked && safety_switching_output;
    n.fwd.field_free = sender_linked && field_free;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS: n.rdata = {19'h0, s.mode, s.found, s.ri_conf, s.cfg,
                               s.mode == S_LOCK};
        REG_BEAM: n.rdata = {28'h0, s.beam};
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata = s.rdata;
  assign beam_code = s.beam;
  assign locked    = s.mode == S_LOCK;
  assign nvm_wr    = s.nvm_wr;
  assign nvm_wdata = s.cfg;
  assign leds      = s.leds;
  assign fwd       = s.fwd;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_max_units;
    s.mode == S_DETECT && chain_valid && chain_count > 3'(MAX_UNITS) |=> s.mode == S_LOCK;
  endproperty
  a_max_units: assert property (p_max_units) else $error("too many units accepted");

  property p_beam;
    s.mode == S_DETECT && chain_valid
      |=> beam_code == ($past(is_host) ? $past(beam_dip) : $past(chain_beam));
  endproperty
  a_beam: assert property (p_beam) else $error("beam coding not shared");

  property p_fewer;
    s.mode == S_DETECT && chain_valid && s.cfg.valid && chain_count != 3'h0
      && chain_count < {1'b0, s.cfg.count} |=> locked ##1 locked;
  endproperty
  a_fewer: assert property (p_fewer) else $error("fewer units did not lock");

  property p_more;
    s.mode == S_DETECT && chain_valid && s.cfg.valid && chain_count <= 3'(MAX_UNITS)
      && chain_count > {1'b0, s.cfg.count} && !factory
      |=> s.mode == S_CONFIG && nvm_wr && {1'b0, nvm_wdata.count} == $past(chain_count);
  endproperty
  a_more: assert property (p_more) else $error("larger count not stored");

  property p_adopt;
    s.mode == S_DETECT && chain_valid && !s.cfg.valid && chain_count == 3'h2
      && chain_restart_any && !factory |=> s.cfg.restart && nvm_wr;
  endproperty
  a_adopt: assert property (p_adopt) else $error("interlock not adopted");

  property p_cfg_flash;
    s.mode == S_CONFIG |=> leds.field_green == $past(s.blink);
  endproperty
  a_cfg_flash: assert property (p_cfg_flash) else $error("field not flashing");

  property p_btn_ok;
    s.mode == S_CONFIG && rel && s.btn_ms >= BTN_MIN_T && s.btn_ms <= BTN_MAX_T && !factory
      |=> s.cfg.restart && s.ri_conf && nvm_wr;
  endproperty
  a_btn_ok: assert property (p_btn_ok) else $error("interlock not enabled");

  property p_btn_bad;
    s.mode == S_CONFIG && !s.cfg.restart && (s.btn_ms < BTN_MIN_T || s.btn_ms > BTN_MAX_T)
      |=> !s.cfg.restart;
  endproperty
  a_btn_bad: assert property (p_btn_bad) else $error("bad press changed interlock");

  property p_fwd;
    !sys_rst && sender_linked |=> fwd == {$past(safety_switching_output), $past(field_free)};
  endproperty
  a_fwd: assert property (p_fwd) else $error("status not forwarded");

  property p_lamp;
    !sys_rst && s.mode == S_INIT |=> leds == '1;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp test missing");

  property p_contactor;
    s.cfg.contactor && !factory |=> s.cfg.contactor;
  endproperty
  a_contactor: assert property (p_contactor) else $error("contactor check lost");

  property p_fresh;
    s.mode == S_DETECT && chain_valid && !s.cfg.valid && chain_count != 3'h0
      && chain_count <= 3'(MAX_UNITS) |=> s.mode == S_CONFIG && nvm_wr;
  endproperty
  a_fresh: assert property (p_fresh) else $error("fresh unit not configuring");

  property p_store;
    s.mode == S_DETECT && chain_valid && !s.cfg.valid && chain_count != 3'h0
      && chain_count <= 3'(MAX_UNITS) && !factory
      |=> nvm_wdata.valid && {1'b0, nvm_wdata.count} == $past(chain_count);
  endproperty
  a_store: assert property (p_store) else $error("unit count not stored");

  property p_adopt_cnt;
    s.mode == S_DETECT && chain_valid && !s.cfg.valid && chain_count != 3'h0
      && chain_count <= 3'(MAX_UNITS) && chain_contactor_any && !factory
      |=> s.cfg.contactor && nvm_wr;
  endproperty
  a_adopt_cnt: assert property (p_adopt_cnt) else $error("contactor not adopted");

  property p_load;
    s.mode == S_INIT && tick && s.ms >= LAMP_T && !factory |=> s.cfg == $past(nvm_rd);
  endproperty
  a_load: assert property (p_load) else $error("stored record not loaded");

  property p_led2;
    s.mode == S_CONFIG && s.cfg.count > 2'h1 |=> leds.diag[1] == $past(s.blink);
  endproperty
  a_led2: assert property (p_led2) else $error("cascade indication missing");

  property p_led1;
    s.mode == S_CONFIG |=> leds.diag[0] == ($past(s.cfg.contactor) && $past(s.blink));
  endproperty
  a_led1: assert property (p_led1) else $error("contactor indication wrong");

  property p_sync;
    s.mode == S_RUN && s.ms >= ALIGN_T && !safety_switching_output
      |=> leds.diag[5:4] == {2{$past(top_sync)}}
      && leds.diag[7:6] == {2{$past(bottom_sync)}};
  endproperty
  a_sync: assert property (p_sync) else $error("beam sync indication wrong");

  property p_quality;
    s.mode == S_RUN && s.ms >= ALIGN_T && !safety_switching_output
      |=> leds.diag[0] == ($past(align_level) > 3'h0)
      && leds.diag[3] == ($past(align_level) > 3'h3);
  endproperty
  a_quality: assert property (p_quality) else $error("alignment indication wrong");

  property p_run;
    s.mode == S_RUN |=> leds.sender_state && leds.safety_switching_output;
  endproperty
  a_run: assert property (p_run) else $error("normal indication missing");

  c_config: cover property (s.mode == S_DETECT ##1 s.mode == S_CONFIG);
  c_lock: cover property (s.mode == S_DETECT ##1 s.mode == S_LOCK);
  c_restart: cover property (s.mode == S_CONFIG && !s.ri_conf ##1 s.ri_conf);
  c_run: cover property (s.mode == S_RUN && s.ms >= ALIGN_T && !safety_switching_output);
  c_more: cover property (s.mode == S_DETECT && chain_valid && s.cfg.valid
                          && chain_count > {1'b0, s.cfg.count});
endmodule // ccs_top

/* File: dv/ccs_partner.sv */
`timescale 1ns/100ps
module ccs_partner
  import ccs_pkg::*;
(
  // Clock and power-up.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Chain make-up chosen by the bench.
  input  wire logic [2:0] units,
  input  wire logic       rst_any,
  input  wire logic       cnt_any,
  input  wire logic [3:0] host_dip,
  // Chain and store towards the block.
  output logic            chain_valid,
  output logic [2:0]      chain_count,
  output logic            chain_restart_any,
  output logic            chain_contactor_any,
  output logic [3:0]      chain_beam,
  input  wire logic       nvm_wr,
  input  wire ccs_nvm_t   nvm_wdata,
  output ccs_nvm_t        nvm_rd
);
  ccs_nvm_t   mem_r = '0;
  logic [3:0] dly_r;

  // The store keeps its record over power cycles.
  always @(posedge clk) begin
    if (nvm_wr === 1'b1) mem_r <= nvm_wdata;
    if (sys_rst) dly_r <= '0;
    else if (dly_r != 4'hf) dly_r <= dly_r + 4'h1;
  end

  // The chain answers late; until then the count lines show garbage.
  assign chain_valid         = (dly_r == 4'hf);
  assign chain_count         = chain_valid ? units : ~units;
  assign chain_restart_any   = rst_any;
  assign chain_contactor_any = cnt_any;
  assign chain_beam          = host_dip;
  assign nvm_rd              = mem_r;
endmodule // ccs_partner

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import ccs_pkg::*;
  localparam int TK = 4;
  logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, st, x = 32'd85;
  logic        is_host = 1'b1, cfb = 1'b0, reset_button = 1'b0, top_sync = 1'b0;
  logic        bottom_sync = 1'b0, sso = 1'b1, field_free = 1'b0, sender_linked = 1'b0;
  logic        ra = 1'b0, ca = 1'b0, sv = 1'b0, rr = 1'b0, cc = 1'b0;
  logic        nvm_wr, locked, chain_valid, chain_restart_any, chain_contactor_any;
  logic [2:0]  align_level = '0, units = 3'h2, chain_count;
  logic [3:0]  beam_dip = 4'h5, hdip = 4'h5, chain_beam, beam_code;
  logic [11:0] lv;
  ccs_nvm_t    nvm_rd, nvm_wdata;
  ccs_nvm_t    q[$];
  ccs_led_t    leds;
  ccs_fwd_t    fwd;
  int          num_errors = 0, n_compared = 0, sc = 0;

  assign lv = leds;
  always #5 clk = ~clk;

  ccs_top #(.TICK_CYC(TK)) i_ccs_top (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .is_host(is_host), .beam_dip(beam_dip), .chain_beam(chain_beam),
    .chain_valid(chain_valid), .chain_count(chain_count),
    .chain_restart_any(chain_restart_any), .chain_contactor_any(chain_contactor_any),
    .beam_code(beam_code), .locked(locked), .nvm_rd(nvm_rd), .nvm_wr(nvm_wr),
    .nvm_wdata(nvm_wdata), .contactor_feedback_check(cfb), .reset_button(reset_button),
    .align_level(align_level), .top_sync(top_sync), .bottom_sync(bottom_sync),
    .safety_switching_output(sso), .field_free(field_free), .sender_linked(sender_linked),
    .leds(leds), .fwd(fwd));

  ccs_partner i_ccs_partner (.clk(clk), .sys_rst(sys_rst), .units(units), .rst_any(ra),
    .cnt_any(ca), .host_dip(hdip), .chain_valid(chain_valid), .chain_count(chain_count),
    .chain_restart_any(chain_restart_any), .chain_contactor_any(chain_contactor_any),
    .chain_beam(chain_beam), .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata), .nvm_rd(nvm_rd));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic flash(input int b);
    int t = 0;
    logic p;
    p = lv[b];
    repeat ((2 * FLASH_MS + 8) * TK) begin
      @(posedge clk);
      if (lv[b] !== p) t++;
      p = lv[b];
    end
    cmp(32'(t > 1), 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
    d = reg_rdata;
  endtask

  task automatic setup(input logic r, input logic c, input logic f);
    ra <= r;
    ca <= c;
    cfb <= f;
    tick(1);
  endtask

  // Model of one power cycle: expected mode and store record.
  task automatic up(input logic [2:0] n);
    int m;
    m = (n == 0 || n > 3) ? 4 : !sv ? 2 : (n < sc) ? 4 : (n > sc) ? 2 : 3;
    if (m == 2) begin
      if (!sv) {rr, cc} = {ra, ca | cfb};
      sv = 1'b1;
      sc = n;
      q.push_back(ccs_nvm_t'({1'b1, n[1:0], rr, cc}));
    end
    units <= n;
    sys_rst <= 1'b1;
    tick(20);
    sys_rst <= 1'b0;
    tick(3);
    cmp(32'(lv), 32'hfff);
    tick((LAMP_MS + 3) * TK);
    rd(REG_STATUS, st);
    cmp(st & 32'h1f81, (m << 10) | (32'(n) << 7) | 32'(m == 4));
    cmp(32'(locked), 32'(m == 4));
    cmp(32'(q.size()), 32'h0);
  endtask

  task automatic press(input int ms, input logic ok);
    if (ok) begin
      rr = 1'b1;
      q.push_back(ccs_nvm_t'({1'b1, 2'(sc), rr, cc}));
    end
    reset_button <= 1'b1;
    tick(ms * TK);
    reset_button <= 1'b0;
    tick(4 * TK);
    cmp(32'(q.size()), 32'h0);
  endtask

  task automatic summarize;
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    if (!sys_rst && nvm_wr === 1'b1) begin
      if (q.size() == 0) cmp(32'(nvm_wdata), 32'h3f);
      else cmp(32'(nvm_wdata), 32'(q.pop_front()));
    end
  end

  initial begin
    tick(60000);
    num_errors++;
    summarize();
  end

  initial begin
    setup(1'b1, 1'b0, 1'b1);
    up(3'h2);
    flash(11);
    flash(1);
    flash(0);
    tick(3000 * TK);
    up(3'h2);
    cmp(32'(beam_code), 32'(beam_dip));
    rd(REG_BEAM, st);
    cmp(st, 32'(beam_dip));
    cmp(32'(lv), 32'hb0b);
    sso <= 1'b0;
    align_level <= 3'h3;
    top_sync <= 1'b1;
    tick(ALIGN_MS * TK);
    cmp(32'(lv), 32'h737);
    for (int i = 0; i < 16; i++) begin
      x = xs(x);
      {sso, field_free, sender_linked} <= x[2:0];
      tick(2);
      cmp(32'(fwd), sender_linked ? 32'({sso, field_free}) : 32'h0);
    end
    is_host <= 1'b0;
    beam_dip <= 4'ha;
    hdip <= 4'h6;
    up(3'h3);
    cmp(32'(beam_code), 32'h6);
    up(3'h1);
    up(3'h4);
    rd(8'h0c, st);
    cmp(st, 32'h0);
    rd(REG_CTRL, st);
    cmp(st, 32'h0);
    {sv, rr, cc} = 3'b000;
    q.push_back('0);
    wr(REG_CTRL, 32'h1);
    tick(2);
    cmp(32'(q.size()), 32'h0);
    is_host <= 1'b1;
    setup(1'b0, 1'b0, 1'b0);
    up(3'h2);
    press(600, 1'b0);
    press(1500, 1'b1);
    flash(3);
    summarize();
  end
endmodule // tb_top
